/* hdl/insn_format_pkg.sv */
// Constants and types for the instruction format decoder.
// Assumes 24-bit program words that arrive one per handshake from the fetch stage.
//
// Overview of operation
// - Each single word is 24 bits, top 8 bits are opcode, rest operands.
// - Exactly three opcodes take two program words; every other opcode takes one.
// - Every opcode falls in one of five classes: word/byte, bit, literal, DSP, control.
// - Working-register ops yield first source, moded second source and moded destination.
// - File-register ops yield file address and a select for file or working register zero.
// - Bit ops target moded register or file; bit number is literal or register.
// - Literal moves yield the literal and the register or file that receives it.
// - Literal arithmetic yields first source, literal, and destination only if not source.
// - Multiply-accumulate ops yield accumulator, multiplicands, prefetches and write-back.
// - Other DSP ops yield accumulator, moded operand and literal or register shift.
// - Control ops yield program address where present and table access mode.
package insn_format_pkg;

  localparam int WORD_W   = 24;
  localparam int OPC_MSB  = 23;
  localparam int OPC_LSB  = 16;
  localparam int ADDR_W   = 23;

  // Opcode group is the upper opcode nibble.
  localparam logic [3:0] GRP_CONTROL   = 4'h0;
  localparam logic [3:0] GRP_WORKING_REGISTER_ZERO_LAST = 4'h7;
  localparam logic [3:0] GRP_LIT_MOVE  = 4'h8;
  localparam logic [3:0] GRP_FILE      = 4'h9;
  localparam logic [3:0] GRP_BIT       = 4'hA;
  localparam logic [3:0] GRP_LIT_ARITH = 4'hB;
  localparam logic [3:0] GRP_MAC       = 4'hC;
  localparam logic [3:0] GRP_DSP       = 4'hD;
  localparam logic [3:0] GRP_TABLE     = 4'hE;

  // The three two-word opcodes; codes are arbitrary.
  localparam logic [7:0] OPC_LONG_CALL = 8'h02;
  localparam logic [7:0] OPC_LONG_JUMP = 8'h04;
  localparam logic [7:0] OPC_LOOP      = 8'h08;

  // Opcode flag bits.
  localparam int OPC_BYTE_BIT     = 16;
  localparam int OPC_LIT_FILE_BIT = 19;
  localparam int OPC_TO_SRC_BIT   = 17;

  // Working-register format.
  localparam int SRC1_LSB  = 12;
  localparam int DMODE_LSB = 10;
  localparam int DREG_LSB  = 6;
  localparam int SMODE_LSB = 4;
  localparam int SREG_LSB  = 0;

  // File-register format.
  localparam int FILE_DEST_BIT = 13;
  localparam int FILE_ADDR_W   = 13;

  // Bit format.
  localparam int BIT_TGT_FILE_BIT = 15;
  localparam int BIT_FROM_REG_BIT = 14;
  localparam int BIT_POS_LSB      = 10;
  localparam int BIT_FILE_W       = 10;

  // Literal formats.
  localparam int LIT_MOVE_LSB  = 4;
  localparam int LIT_MOVE_W    = 12;
  localparam int LIT_FMOVE_LSB = 8;
  localparam int LIT_FMOVE_W   = 8;
  localparam int LIT_ARITH_LSB = 6;
  localparam int LIT_ARITH_W   = 6;

  // Multiply-accumulate format.
  localparam int ACC_BIT    = 15;
  localparam int MULX_LSB   = 13;
  localparam int MULY_LSB   = 11;
  localparam int XPF_OP_LSB = 8;
  localparam int XPF_DS_LSB = 6;
  localparam int YPF_OP_LSB = 4;
  localparam int YPF_DS_LSB = 2;
  localparam int WB_LSB     = 0;

  // Other DSP format.
  localparam int SHIFT_REG_BIT = 14;
  localparam int SHIFT_LSB     = 8;
  localparam int SHIFT_W       = 6;

  // Control formats.
  localparam int TBL_MODE_LSB  = 14;
  localparam int ADDR_HI_W     = 7;

  typedef enum logic [4:0] {
    CLS_WORD_BYTE = 5'b00001,
    CLS_BIT       = 5'b00010,
    CLS_LITERAL   = 5'b00100,
    CLS_DSP       = 5'b01000,
    CLS_CONTROL   = 5'b10000
  } insn_class_t;

  typedef enum logic [1:0] {
    ST_FIRST  = 2'b01,
    ST_SECOND = 2'b10
  } fetch_state_t;

endpackage : insn_format_pkg

/* hdl/first_word_hold.sv */
// Holds the first word of a two-word instruction until its partner arrives.
// Assumes the caller pulses load only on a taken first word.
`timescale 1ns/1ps
module first_word_hold
  import insn_format_pkg::*;
(
  input  wire logic              core_clk,  // Core clock.
  input  wire logic              rst,       // Asynchronous reset.
  input  wire logic              load,      // Capture word_in.
  input  wire logic [WORD_W-1:0] word_in,   // Word to hold.
  output logic      [WORD_W-1:0] word_out   // Held word, registered.
);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_out <= '0;
    end else if (load) begin
      word_out <= word_in;
    end
  end

endmodule : first_word_hold

/* hdl/insn_format_decoder.sv */
// Splits program words into opcode, class and operand fields, one issue per instruction.
// Assumes the fetch stage presents one word per fetch_valid pulse, in program order.
`timescale 1ns/1ps
module insn_format_decoder
  import insn_format_pkg::*;
(
  input  wire logic              core_clk,                   // Core clock, 200 MHz.
  input  wire logic              rst,                        // Asynchronous reset.
  input  wire logic              fetch_valid,                // Word present this cycle.
  input  wire logic [WORD_W-1:0] fetch_word,                 // Program word.
  output logic                   issue_valid,                // One-cycle issue pulse.
  output logic [7:0]             opcode,                     // Opcode field.
  output insn_class_t            op_class,                   // One-hot class.
  output logic                   two_word,                   // Instruction took two words.
  output logic                   byte_op,                    // Byte rather than word.
  output logic [3:0]             first_source_register,      // First source.
  output logic [3:0]             second_source_register,     // Second source or target.
  output logic [1:0]             second_mode,                // Second source modifier.
  output logic [3:0]             destination_register,       // Destination register.
  output logic [1:0]             dest_mode,                  // Destination modifier.
  output logic                   dest_valid,                 // Destination field used.
  output logic [12:0]            file_addr,                  // File register address.
  output logic                   file_valid,                 // File address used.
  output logic                   to_working_register_zero,   // Result to working reg zero.
  output logic [3:0]             bit_pos,                    // Bit number or its register.
  output logic                   bit_from_reg,               // Bit number from register.
  output logic [15:0]            literal,                    // Literal operand.
  output logic                   multiply_accumulate_class,  // Multiplying DSP op.
  output logic                   acc_sel,                    // Accumulator A=0, B=1.
  output logic [1:0]             mul_x_sel,                  // First multiplicand.
  output logic [1:0]             mul_y_sel,                  // Second multiplicand.
  output logic [2:0]             x_prefetch_op,              // X prefetch, 0 is none.
  output logic [1:0]             x_prefetch_dst,             // X prefetch destination.
  output logic [1:0]             y_prefetch_op,              // Y prefetch, 0 is none.
  output logic [1:0]             y_prefetch_dst,             // Y prefetch destination.
  output logic [1:0]             acc_writeback,              // Write-back, 0 is none.
  output logic                   shift_from_reg,             // Shift held in a register.
  output logic [5:0]             shift_amount,               // Literal or register number.
  output logic [ADDR_W-1:0]      prog_addr,                  // Program address.
  output logic                   addr_valid,                 // Program address used.
  output logic [1:0]             table_mode                  // Table access mode.
);

  // ----------------------------------------------------------------
  // Word sequencing
  // ----------------------------------------------------------------
  fetch_state_t      state_q;
  logic [WORD_W-1:0] first_q;
  logic              first_is_long;
  logic              take_first;
  logic              take_second;

  function automatic logic is_long(input logic [7:0] opc);
    return (opc == OPC_LONG_CALL) || (opc == OPC_LONG_JUMP) || (opc == OPC_LOOP);
  endfunction : is_long

  assign first_is_long = is_long(fetch_word[OPC_MSB:OPC_LSB]);
  assign take_first    = fetch_valid && (state_q == ST_FIRST);
  assign take_second   = fetch_valid && (state_q == ST_SECOND);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_FIRST;
    end else begin
      unique case (state_q)
        ST_FIRST: begin
          if (take_first && first_is_long) begin
            state_q <= ST_SECOND;
          end
        end
        ST_SECOND: begin
          if (take_second) begin
            state_q <= ST_FIRST;
          end
        end
        default: state_q <= ST_FIRST;
      endcase
    end
  end

  first_word_hold u_hold (
    .core_clk (core_clk),
    .rst      (rst),
    .load     (take_first && first_is_long),
    .word_in  (fetch_word),
    .word_out (first_q)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // The opcode word is the held word while a second word completes it.
  logic [WORD_W-1:0] w;
  logic [7:0]        opc;
  logic [3:0]        grp;
  logic              issue_d;

  assign w       = take_second ? first_q : fetch_word;
  assign opc     = w[OPC_MSB:OPC_LSB];
  assign grp     = opc[7:4];
  assign issue_d = take_second || (take_first && !first_is_long);

  insn_class_t class_d;

  always_comb begin
    if (grp >= 4'h1 && grp <= GRP_WORKING_REGISTER_ZERO_LAST) begin
      class_d = CLS_WORD_BYTE;
    end else if (grp == GRP_FILE) begin
      class_d = CLS_WORD_BYTE;
    end else if (grp == GRP_BIT) begin
      class_d = CLS_BIT;
    end else if (grp == GRP_LIT_MOVE || grp == GRP_LIT_ARITH) begin
      class_d = CLS_LITERAL;
    end else if (grp == GRP_MAC || grp == GRP_DSP) begin
      class_d = CLS_DSP;
    end else begin
      class_d = CLS_CONTROL;
    end
  end

  // ----------------------------------------------------------------
  // Issue register
  // ----------------------------------------------------------------
  // Every operand field is cleared at each issue before its class loads it, so stale operands never leak into a later class.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      issue_valid <= 1'b0;
    end else begin
      issue_valid <= issue_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      opcode <= 8'h00;  op_class <= CLS_CONTROL;  two_word <= 1'b0;  byte_op <= 1'b0;
      first_source_register <= 4'h0;  second_source_register <= 4'h0;  second_mode <= 2'h0;
      destination_register <= 4'h0;  dest_mode <= 2'h0;  dest_valid <= 1'b0;
      file_addr <= 13'h0000;  file_valid <= 1'b0;  to_working_register_zero <= 1'b0;
      bit_pos <= 4'h0;  bit_from_reg <= 1'b0;  literal <= 16'h0000;
      multiply_accumulate_class <= 1'b0;  acc_sel <= 1'b0;
      mul_x_sel <= 2'h0;  mul_y_sel <= 2'h0;  x_prefetch_op <= 3'h0;  x_prefetch_dst <= 2'h0;
      y_prefetch_op <= 2'h0;  y_prefetch_dst <= 2'h0;  acc_writeback <= 2'h0;
      shift_from_reg <= 1'b0;  shift_amount <= 6'h00;
      prog_addr <= 23'h000000;  addr_valid <= 1'b0;  table_mode <= 2'h0;
    end else if (issue_d) begin
      opcode   <= opc;
      op_class <= class_d;
      two_word <= take_second;
      byte_op  <= w[OPC_BYTE_BIT];
      first_source_register <= 4'h0;  second_source_register <= 4'h0;  second_mode <= 2'h0;
      destination_register <= 4'h0;  dest_mode <= 2'h0;  dest_valid <= 1'b0;
      file_addr <= 13'h0000;  file_valid <= 1'b0;  to_working_register_zero <= 1'b0;
      bit_pos <= 4'h0;  bit_from_reg <= 1'b0;  literal <= 16'h0000;
      multiply_accumulate_class <= 1'b0;  acc_sel <= 1'b0;
      mul_x_sel <= 2'h0;  mul_y_sel <= 2'h0;  x_prefetch_op <= 3'h0;  x_prefetch_dst <= 2'h0;
      y_prefetch_op <= 2'h0;  y_prefetch_dst <= 2'h0;  acc_writeback <= 2'h0;
      shift_from_reg <= 1'b0;  shift_amount <= 6'h00;
      prog_addr <= 23'h000000;  addr_valid <= 1'b0;  table_mode <= 2'h0;
      if (grp >= 4'h1 && grp <= GRP_WORKING_REGISTER_ZERO_LAST) begin
        first_source_register  <= w[SRC1_LSB +: 4];
        second_source_register <= w[SREG_LSB +: 4];
        second_mode            <= w[SMODE_LSB +: 2];
        destination_register   <= w[DREG_LSB +: 4];
        dest_mode              <= w[DMODE_LSB +: 2];
        dest_valid             <= 1'b1;
      end else if (grp == GRP_FILE) begin
        file_addr                <= w[FILE_ADDR_W-1:0];
        file_valid               <= 1'b1;
        to_working_register_zero <= w[FILE_DEST_BIT];
      end else if (grp == GRP_BIT) begin
        bit_pos      <= w[BIT_POS_LSB +: 4];
        bit_from_reg <= w[BIT_FROM_REG_BIT];
        if (w[BIT_TGT_FILE_BIT]) begin
          file_addr  <= {3'h0, w[BIT_FILE_W-1:0]};
          file_valid <= 1'b1;
        end else begin
          second_source_register <= w[SREG_LSB +: 4];
          second_mode            <= w[SMODE_LSB +: 2];
        end
      end else if (grp == GRP_LIT_MOVE) begin
        if (w[OPC_LIT_FILE_BIT]) begin
          literal    <= {8'h00, w[LIT_FMOVE_LSB +: LIT_FMOVE_W]};
          file_addr  <= {5'h00, w[LIT_FMOVE_W-1:0]};
          file_valid <= 1'b1;
        end else begin
          literal              <= {4'h0, w[LIT_MOVE_LSB +: LIT_MOVE_W]};
          destination_register <= w[SREG_LSB +: 4];
          dest_valid           <= 1'b1;
        end
      end else if (grp == GRP_LIT_ARITH) begin
        first_source_register <= w[SRC1_LSB +: 4];
        literal               <= {10'h000, w[LIT_ARITH_LSB +: LIT_ARITH_W]};
        if (!w[OPC_TO_SRC_BIT]) begin
          destination_register <= w[SREG_LSB +: 4];
          dest_mode            <= w[SMODE_LSB +: 2];
          dest_valid           <= 1'b1;
        end
      end else if (grp == GRP_MAC) begin
        multiply_accumulate_class <= 1'b1;
        acc_sel        <= w[ACC_BIT];
        mul_x_sel      <= w[MULX_LSB +: 2];
        mul_y_sel      <= w[MULY_LSB +: 2];
        x_prefetch_op  <= w[XPF_OP_LSB +: 3];
        x_prefetch_dst <= w[XPF_DS_LSB +: 2];
        y_prefetch_op  <= w[YPF_OP_LSB +: 2];
        y_prefetch_dst <= w[YPF_DS_LSB +: 2];
        acc_writeback  <= w[WB_LSB +: 2];
      end else if (grp == GRP_DSP) begin
        acc_sel                <= w[ACC_BIT];
        shift_from_reg         <= w[SHIFT_REG_BIT];
        shift_amount           <= w[SHIFT_LSB +: SHIFT_W];
        second_source_register <= w[SREG_LSB +: 4];
        second_mode            <= w[SMODE_LSB +: 2];
      end else if (grp == GRP_TABLE) begin
        table_mode <= w[TBL_MODE_LSB +: 2];
      end else if (take_second) begin
        // Low address bits ride in the first word, high bits in the second.
        prog_addr  <= {fetch_word[ADDR_HI_W-1:0], first_q[15:0]};
        addr_valid <= 1'b1;
        if (opc == OPC_LOOP) begin
          literal <= {8'h00, fetch_word[OPC_MSB:OPC_LSB]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  long_holds_issue_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (take_first && first_is_long) |=> !issue_valid)
    else $error("Issue seen right after a first word of a two-word opcode.");

  single_issue_next_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (take_first && !first_is_long) |=> (issue_valid && !two_word))
    else $error("Single-word instruction did not issue next cycle.");

  long_opcode_set_a: assert property (
    @(posedge core_clk) disable iff (rst)
    issue_valid |-> (two_word == is_long(opcode)))
    else $error("Two-word flag disagrees with opcode.");

  opcode_copy_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (take_first && !first_is_long) |=> (opcode == $past(fetch_word[OPC_MSB:OPC_LSB])))
    else $error("Opcode is not the leading eight bits.");

  class_onehot_a: assert property (
    @(posedge core_clk) disable iff (rst)
    issue_valid |-> ($onehot(op_class)
      && ((op_class == CLS_BIT) == (opcode[7:4] == GRP_BIT))
      && ((op_class == CLS_DSP) == (opcode[7:4] == GRP_MAC || opcode[7:4] == GRP_DSP))))
    else $error("Class is not one of five.");

  file_dest_sel_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (take_first && fetch_word[OPC_MSB -: 4] == GRP_FILE)
      |=> (to_working_register_zero == $past(fetch_word[FILE_DEST_BIT]) && file_valid))
    else $error("File destination select not taken from its bit.");

  lit_arith_dest_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (issue_valid && opcode[7:4] == GRP_LIT_ARITH) |-> (dest_valid != opcode[1]))
    else $error("Literal arithmetic destination use is wrong.");

  mac_acc_field_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (take_first && fetch_word[OPC_MSB -: 4] == GRP_MAC)
      |=> (multiply_accumulate_class && acc_sel == $past(fetch_word[ACC_BIT])))
    else $error("Accumulator select not taken.");

  long_addr_join_a: assert property (
    @(posedge core_clk) disable iff (rst)
    take_second |=> (addr_valid && two_word
      && prog_addr == {$past(fetch_word[ADDR_HI_W-1:0]), $past(first_q[15:0])}))
    else $error("Two-word program address not joined.");

endmodule : insn_format_decoder

/* test/fetch_model.sv */
// Behavioural model of the program fetch stage that feeds the instruction decoder.
// Assumes the caller enters its tasks just after a falling edge of core_clk.
`timescale 1ns/1ps
module fetch_model
  import insn_format_pkg::*;
(
  input  wire logic              core_clk,     // Core clock.
  output logic                   fetch_valid,  // Word offered this cycle.
  output logic      [WORD_W-1:0] fetch_word    // Program word.
);
  initial begin
    fetch_valid = 1'b0;
    fetch_word  = '0;
  end

  // The word lines keep changing while idle, so the decoder cannot lean on a stale word.
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      fetch_valid = 1'b0;
      fetch_word  = {fetch_word[WORD_W-2:0], ~fetch_word[WORD_W-1]};
      @(negedge core_clk);
    end
  endtask : idle

  // A gap of zero leaves valid high, so the next word follows back to back.
  task automatic send(input logic [WORD_W-1:0] w, input int gap);
    fetch_valid = 1'b1;
    fetch_word  = w;
    @(negedge core_clk);
    if (gap > 0) begin
      idle(gap);
    end
  endtask : send
endmodule : fetch_model

/* test/dsp_core_instruction_format_decoder_test.sv */
// Self-checking bench for the instruction format decoder, with a field-level reference model.
// Assumes the fetch model in fetch_model.sv and the decoder package are compiled first.
`timescale 1ns/1ps
module dsp_core_instruction_format_decoder_test
  import insn_format_pkg::*;
;
  typedef struct packed {
    logic [7:0] opc; insn_class_t cls; logic two; logic byt;
    logic [3:0] fsr; logic [3:0] ssr; logic [1:0] smode; logic [3:0] dreg; logic [1:0] dmode;
    logic dval; logic [12:0] faddr; logic fval; logic tw0; logic [3:0] bpos; logic bfr;
    logic [15:0] lit; logic mac; logic acc; logic [1:0] mx; logic [1:0] my; logic [2:0] xop;
    logic [1:0] xdst; logic [1:0] yop; logic [1:0] ydst; logic [1:0] wb; logic sfr;
    logic [5:0] samt; logic [ADDR_W-1:0] paddr; logic aval; logic [1:0] tmode;
  } exp_t;

  logic              core_clk;
  logic              rst;
  logic              fetch_valid;
  logic [WORD_W-1:0] fetch_word;
  logic              issue_valid;
  exp_t              seen;
  exp_t              eq[$];
  logic              pend;
  logic [WORD_W-1:0] first_w;
  logic [15:0]       rnd;
  int                err_total;
  int                n_checks;

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;

  fetch_model fm (.core_clk(core_clk), .fetch_valid(fetch_valid), .fetch_word(fetch_word));

  insn_format_decoder uut (
    .core_clk(core_clk), .rst(rst), .fetch_valid(fetch_valid), .fetch_word(fetch_word),
    .issue_valid(issue_valid), .opcode(seen.opc), .op_class(seen.cls), .two_word(seen.two),
    .byte_op(seen.byt), .first_source_register(seen.fsr), .second_source_register(seen.ssr),
    .second_mode(seen.smode), .destination_register(seen.dreg), .dest_mode(seen.dmode),
    .dest_valid(seen.dval), .file_addr(seen.faddr), .file_valid(seen.fval),
    .to_working_register_zero(seen.tw0), .bit_pos(seen.bpos), .bit_from_reg(seen.bfr),
    .literal(seen.lit), .multiply_accumulate_class(seen.mac), .acc_sel(seen.acc),
    .mul_x_sel(seen.mx), .mul_y_sel(seen.my), .x_prefetch_op(seen.xop),
    .x_prefetch_dst(seen.xdst), .y_prefetch_op(seen.yop), .y_prefetch_dst(seen.ydst),
    .acc_writeback(seen.wb), .shift_from_reg(seen.sfr), .shift_amount(seen.samt),
    .prog_addr(seen.paddr), .addr_valid(seen.aval), .table_mode(seen.tmode));

  // ----------------------------------------------------------------
  // Reference model and checking
  // ----------------------------------------------------------------
  function automatic logic is_two(input logic [7:0] o);
    return (o == OPC_LONG_CALL) || (o == OPC_LONG_JUMP) || (o == OPC_LOOP);
  endfunction : is_two

  function automatic exp_t model(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] s);
    exp_t       e;
    logic [3:0] g;
    e = '0;
    g = w[23:20];
    e.opc = w[23:16];
    e.byt = w[16];
    e.cls = CLS_CONTROL;
    case (g)
      GRP_FILE: begin
        e.cls = CLS_WORD_BYTE; e.faddr = w[12:0]; e.tw0 = w[13]; e.fval = 1'b1;
      end
      GRP_LIT_MOVE: begin
        e.cls = CLS_LITERAL;
        if (w[19]) begin
          e.lit = {8'h00, w[15:8]}; e.faddr = {5'h00, w[7:0]}; e.fval = 1'b1;
        end else begin
          e.lit = {4'h0, w[15:4]}; e.dreg = w[3:0]; e.dval = 1'b1;
        end
      end
      GRP_BIT: begin
        e.cls = CLS_BIT; e.bfr = w[14]; e.bpos = w[13:10];
        if (w[15]) begin
          e.faddr = {3'h0, w[9:0]}; e.fval = 1'b1;
        end else begin
          e.ssr = w[3:0]; e.smode = w[5:4];
        end
      end
      GRP_LIT_ARITH: begin
        e.cls = CLS_LITERAL; e.fsr = w[15:12]; e.lit = {10'h000, w[11:6]};
        if (!w[17]) begin
          e.dreg = w[3:0]; e.dmode = w[5:4]; e.dval = 1'b1;
        end
      end
      GRP_MAC: begin
        e.cls = CLS_DSP; e.mac = 1'b1; e.acc = w[15]; e.mx = w[14:13]; e.my = w[12:11];
        e.xop = w[10:8]; e.xdst = w[7:6]; e.yop = w[5:4]; e.ydst = w[3:2]; e.wb = w[1:0];
      end
      GRP_DSP: begin
        e.cls = CLS_DSP; e.acc = w[15]; e.sfr = w[14]; e.samt = w[13:8];
        e.ssr = w[3:0]; e.smode = w[5:4];
      end
      GRP_TABLE: e.tmode = w[15:14];
      default: begin
        if (g != GRP_CONTROL && g <= GRP_WORKING_REGISTER_ZERO_LAST) begin
          e.cls = CLS_WORD_BYTE; e.fsr = w[15:12]; e.dmode = w[11:10]; e.dreg = w[9:6];
          e.smode = w[5:4]; e.ssr = w[3:0]; e.dval = 1'b1;
        end
      end
    endcase
    if (is_two(w[23:16])) begin
      e.two = 1'b1; e.aval = 1'b1; e.paddr = {s[6:0], w[15:0]};
      if (w[23:16] == OPC_LOOP) e.lit = {8'h00, s[23:16]};
    end
    return e;
  endfunction : model

  task automatic chk(input string name, input logic [117:0] sv, input logic [117:0] ev);
    n_checks++;
    if (sv !== ev) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, ev, sv);
    end
  endtask : chk

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Every issue pulse must match the oldest instruction completed by the stimulus.
  always @(negedge core_clk) begin
    if (rst === 1'b0 && issue_valid !== 1'b0) begin
      if (eq.size() == 0) chk("issue_valid", {117'h0, issue_valid}, '0);
      else chk("fields", seen, eq.pop_front());
    end
  end

  initial begin
    repeat (50000) @(posedge core_clk);
    err_total++;
    $display("[ERR] run length expected done seen hung");
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {1'b0, x[15:1]} ^ (x[0] ? 16'hB400 : 16'h0000);
  endfunction : lfsr

  task automatic rand_word(output logic [WORD_W-1:0] w);
    logic [15:0] a;
    rnd = lfsr(rnd);
    a = rnd;
    rnd = lfsr(rnd);
    w = {a[7:0], rnd};
  endtask : rand_word

  // The expectation is queued before the word goes out, as its issue follows later.
  task automatic put(input logic [WORD_W-1:0] w, input int gap);
    if (pend) begin
      eq.push_back(model(first_w, w));
      pend = 1'b0;
    end else if (is_two(w[23:16])) begin
      pend = 1'b1;
      first_w = w;
    end else begin
      eq.push_back(model(w, '0));
    end
    fm.send(w, gap);
  endtask : put

  task automatic drain(input string name);
    for (int i = 0; i < 20 && eq.size() > 0; i++) fm.idle(1);
    if (eq.size() != 0) begin
      err_total++;
      $display("[ERR] %s pending expected 0 seen %0d", name, eq.size());
      give_verdict();
    end
    $display("test %s done", name);
  endtask : drain

  task automatic check_reset;
    exp_t r;
    r = '0;
    r.cls = CLS_CONTROL;
    chk("reset fields", seen, r);
    chk("reset issue", {117'h0, issue_valid}, '0);
  endtask : check_reset

  initial begin
    logic [WORD_W-1:0] w;
    logic [7:0]        two_opc [3];
    rst = 1'b1; pend = 1'b0; rnd = 16'hECB6; err_total = 0; n_checks = 0;
    two_opc = '{OPC_LONG_CALL, OPC_LONG_JUMP, OPC_LOOP};
    repeat (2) @(negedge core_clk);
    check_reset();
    rst = 1'b0;
    @(negedge core_clk);
    for (int g = 0; g < 16; g++) begin
      rand_word(w);
      w[23:20] = g[3:0];
      put(w, (g == 15) ? 1 : 0);
    end
    drain("groups");
    // Both back-to-back and delayed second words, each followed at once by a single word.
    for (int k = 0; k < 6; k++) begin
      rand_word(w);
      put({two_opc[k % 3], w[15:0]}, (k / 3) * 3);
      rand_word(w);
      put(w, 0);
      rand_word(w);
      put({4'h1, w[19:0]}, 0);
    end
    fm.idle(1);
    drain("two_word");
    for (int i = 0; i < 150; i++) begin
      rand_word(w);
      put(w, (i == 149) ? 1 : rnd[0]);
    end
    // The random run may stop on a first word; complete it so the reset test starts clean.
    if (pend) put(w, 1);
    drain("random");
    // A reset between the two words must drop the held first word.
    rand_word(w);
    put({OPC_LONG_JUMP, w[15:0]}, 1);
    rst = 1'b1;
    pend = 1'b0;
    repeat (2) @(negedge core_clk);
    check_reset();
    rst = 1'b0;
    @(negedge core_clk);
    rand_word(w);
    put({GRP_FILE, w[19:0]}, 1);
    drain("mid_reset");
    give_verdict();
  end
endmodule : dsp_core_instruction_format_decoder_test
